// ---- include/fcsu_regs.vh ----
`ifndef FCSU_REGS_VH
`define FCSU_REGS_VH

// ----------------------------------------------------------------
// Operation codes presented by the issue logic.
// ----------------------------------------------------------------
`define FCSU_OP_FLT          3'h0
`define FCSU_OP_INT          3'h1
`define FCSU_OP_FSUB         3'h2
`define FCSU_OP_FSTCR        3'h3
`define FCSU_OP_FXCR         3'h4

// ----------------------------------------------------------------
// Precision field codes.
// ----------------------------------------------------------------
`define FCSU_PREC_SINGLE     2'h0
`define FCSU_PREC_DOUBLE     2'h1

// ----------------------------------------------------------------
// Control register numbers.
// ----------------------------------------------------------------
`define FCSU_CR_SCRATCH      6'h00
`define FCSU_CR_CAUSE        6'h01
`define FCSU_CR_RO_LAST      6'h08
`define FCSU_CR_UNIMP_LAST   6'h3D
`define FCSU_CR_STATUS       6'h3E
`define FCSU_CR_CONTROL      6'h3F
`define FCSU_CR_RESET        32'h00000000

// ----------------------------------------------------------------
// Control and status register fields.
// ----------------------------------------------------------------
`define FCSU_CTL_RM_HI       15
`define FCSU_CTL_RM_LO       14
`define FCSU_CTL_INX_EN      0
`define FCSU_CTL_WMASK       32'h0000C001
`define FCSU_STS_WMASK       32'h0000001F
`define FCSU_STS_INX         0
`define FCSU_STS_OVF         1
`define FCSU_STS_UNF         2
`define FCSU_STS_IOV         3
`define FCSU_STS_RSV         4

// ----------------------------------------------------------------
// Rounding modes.
// ----------------------------------------------------------------
`define FCSU_RM_NEAR         2'h0
`define FCSU_RM_ZERO         2'h1
`define FCSU_RM_MINUS        2'h2
`define FCSU_RM_PLUS         2'h3

// ----------------------------------------------------------------
// Exponent constants, internal format uses the double bias.
// ----------------------------------------------------------------
`define FCSU_DBL_BIAS        13'h03FF
`define FCSU_SGL_REBIAS      14'h0380
`define FCSU_INT_EXP         13'h041E
`define FCSU_INT_OVF_EXP     13'h001E
`define FCSU_DBL_EMAX        14'h07FF
`define FCSU_SGL_EMAX        14'h00FF

`endif

// ---- hdl/fcsu_round.v ----
`timescale 1ns/10ps
`include "fcsu_regs.vh"

// ----------------------------------------------------------------
// Normalise, round and pack an internal result to single or double.
// ----------------------------------------------------------------
module fcsu_round (
	input  wire        sign,
	input  wire [12:0] expIn,
	input  wire [63:0] mantIn,
	input  wire        isDouble,
	input  wire [1:0]  rndMode,
	output reg  [63:0] rounded,
	output reg         ovf,
	output reg         unf,
	output reg         inexact
);

	// Counts leading zeros, 64 for an all-zero value.
	function [6:0] clz64;
		input [63:0] v;
		integer i;
		reg     found;
		begin
			clz64 = 7'h00;
			found = 1'b0;
			for (i = 63; i >= 0; i = i - 1) begin
				if (v[i])
					found = 1'b1;
				else if (!found)
					clz64 = clz64 + 7'h01;
			end
		end
	endfunction

	// Decides whether the kept fraction is bumped by one unit.
	function roundUp;
		input [1:0] mode;
		input       s;
		input       lsb;
		input       g;
		input       st;
		begin
			case (mode)
				`FCSU_RM_NEAR:  roundUp = g & (st | lsb);
				`FCSU_RM_MINUS: roundUp = s & (g | st);
				`FCSU_RM_PLUS:  roundUp = ~s & (g | st);
				default:        roundUp = 1'b0;
			endcase
		end
	endfunction

	reg [6:0]  lz;     // Normalising shift.
	reg [63:0] norm;   // Mantissa with its leading one at bit 63.
	reg [13:0] eF;     // Target-biased exponent before rounding.
	reg [53:0] keep;   // Kept fraction including hidden bit.
	reg [53:0] rnd;    // Kept fraction after rounding.
	reg        g;      // Guard bit.
	reg        st;     // Sticky bit.
	reg        carry;  // Rounding carried into a new binade.
	reg [13:0] eR;     // Exponent after rounding.

	// Whole datapath is combinational; the caller registers the result.
	always @* begin
		lz    = clz64(mantIn);
		norm  = mantIn << lz;
		eF    = {1'b0, expIn} - {7'h00, lz};
		if (!isDouble)
			eF = eF - `FCSU_SGL_REBIAS;
		if (isDouble) begin
			keep = {1'b0, norm[63:11]};
			g    = norm[10];
			st   = |norm[9:0];
		end else begin
			keep = {30'h0, norm[63:40]};
			g    = norm[39];
			st   = |norm[38:0];
		end
		rnd   = keep + {53'h0, roundUp(rndMode, sign, keep[0], g, st)};
		carry = isDouble ? rnd[53] : rnd[24];
		eR    = eF + {13'h0, carry};
		ovf   = 1'b0;
		unf   = 1'b0;
		inexact = g | st;
		if (mantIn == 64'h0) begin
			// Exact zero keeps the sign chosen by the caller.
			rounded = {sign, 63'h0};
			inexact = 1'b0;
		end else if (eF[13] || eF == 14'h0) begin
			// Below the normal range: flush to zero, sign in bit 63 even for single.
			unf     = 1'b1;
			inexact = 1'b1;
			rounded = {sign, 63'h0};
		end else if (eR >= (isDouble ? `FCSU_DBL_EMAX : `FCSU_SGL_EMAX)) begin
			// Above the range: signed infinity.
			ovf     = 1'b1;
			inexact = 1'b1;
			rounded = isDouble ? {sign, 11'h7FF, 52'h0} : {32'h0, sign, 8'hFF, 23'h0};
		end else if (isDouble) begin
			rounded = {sign, eR[10:0], carry ? 52'h0 : rnd[51:0]};
		end else begin
			rounded = {32'h0, sign, eR[7:0], carry ? 23'h0 : rnd[22:0]};
		end
		if (!isDouble && mantIn == 64'h0)
			rounded = {32'h0, sign, 31'h0};
	end

endmodule

// ---- hdl/fcsu_unit.v ----
// Overview of operation
// - Convert signed integer source to float.
// - Integer source always single width.
// - Zero destination or disabled unit: unimplemented.
// - Precision code 00 single, 01 double.
// - Reserved operands trap, else IEEE subtract.
// - Subtract accepts all eight precision mixes.
// - Overflow, underflow; inexact only when enabled.
// - Float to 32-bit integer, current rounding.
// - Exponent thirty or more, integer overflow.
// - Store writes general register to control.
// - Registers 0-8 supervisor, 62-63 anyone.
// - Store to read-only registers does nothing.
// - Unimplemented registers: nop or privilege trap.
// - Exchange writes new, returns old value.
// - Exchange of read-only registers only reads.
// - Exchange unimplemented: zero or privilege trap.
`timescale 1ns/10ps
`include "fcsu_regs.vh"

module fcsu_unit (
	input  wire        mclk,
	input  wire        resetn,
	input  wire        opValid,
	input  wire [2:0]  opCode,
	input  wire [4:0]  destReg,
	input  wire [1:0]  srcAPrecisionField,
	input  wire [1:0]  srcBPrecisionField,
	input  wire [1:0]  destPrecisionField,
	input  wire [5:0]  fpCtlSel,
	input  wire [63:0] srcAData,
	input  wire [63:0] srcBData,
	input  wire        supervisorMode,
	input  wire        fpuEnable,
	output reg         doneValid,
	output reg  [63:0] resultData,
	output reg  [4:0]  resultDest,
	output reg         resultDouble,
	output reg         resultWrite,
	output reg         excUnimpl,
	output reg         excReserved,
	output reg         excOverflow,
	output reg         excUnderflow,
	output reg         excInexact,
	output reg         excIntOverflow,
	output reg         excPrivilege
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------

	// Unpacks an operand to {reserved, sign, exp11, mant64} with double bias.
	function [76:0] unpackOp;
		input [63:0] v;
		input        dbl;
		reg   [10:0] e;
		reg          rsv;
		reg   [63:0] m;
		begin
			if (dbl) begin
				e   = v[62:52];
				rsv = (&v[62:52]) | (v[62:52] == 11'h0 && v[51:0] != 52'h0);
				m   = (v[62:52] == 11'h0) ? 64'h0 : {1'b1, v[51:0], 11'h0};
			end else begin
				e   = (v[30:23] == 8'h0) ? 11'h0 : {3'h0, v[30:23]} + 11'h380;
				rsv = (&v[30:23]) | (v[30:23] == 8'h0 && v[22:0] != 23'h0);
				m   = (v[30:23] == 8'h0) ? 64'h0 : {1'b1, v[22:0], 40'h0};
			end
			unpackOp = {rsv, dbl ? v[63] : v[31], e, m};
		end
	endfunction

	// Decides whether a truncated integer is bumped by one.
	function roundUp;
		input [1:0] mode;
		input       s;
		input       lsb;
		input       g;
		input       st;
		begin
			case (mode)
				`FCSU_RM_NEAR:  roundUp = g & (st | lsb);
				`FCSU_RM_MINUS: roundUp = s & (g | st);
				`FCSU_RM_PLUS:  roundUp = ~s & (g | st);
				default:        roundUp = 1'b0;
			endcase
		end
	endfunction

	// Tells whether a precision code is one of the two legal ones.
	function precLegal;
		input [1:0] p;
		begin
			precLegal = (p == `FCSU_PREC_SINGLE) || (p == `FCSU_PREC_DOUBLE);
		end
	endfunction

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	reg [31:0] ctlScratch;  // Register 0, supervisor read/write.
	reg [6:0]  ctlCause;    // Register 1, cause bits of the last trap.
	reg [31:0] ctlStatus;   // Register 62, sticky event flags.
	reg [31:0] ctlControl;  // Register 63, rounding mode and inexact enable.

	wire [1:0] rndMode = ctlControl[`FCSU_CTL_RM_HI:`FCSU_CTL_RM_LO];
	wire       inxEn   = ctlControl[`FCSU_CTL_INX_EN];

	// ------------------------------------------------------------
	// Operand unpacking and subtraction datapath
	// ------------------------------------------------------------
	wire        dblA = (srcAPrecisionField == `FCSU_PREC_DOUBLE);
	wire        dblB = (srcBPrecisionField == `FCSU_PREC_DOUBLE);
	wire        dblD = (destPrecisionField == `FCSU_PREC_DOUBLE);
	wire [76:0] ua   = unpackOp(srcAData, dblA);
	wire [76:0] ub   = unpackOp(srcBData, dblB);

	reg         aBig;     // First source has the larger magnitude.
	reg  [10:0] bigE;     // Larger operand exponent.
	reg  [10:0] smlE;     // Smaller operand exponent.
	reg  [63:0] bigM;     // Larger operand mantissa.
	reg  [63:0] smlM;     // Smaller operand mantissa.
	reg         bigS;     // Effective sign of larger operand.
	reg         smlS;     // Effective sign of smaller operand.
	reg  [10:0] diff;     // Alignment distance.
	reg  [63:0] smlSh;    // Aligned smaller mantissa.
	reg         lost;     // Bits shifted out during alignment.
	reg  [64:0] sum;      // Raw magnitude sum or difference.
	reg  [63:0] subMant;  // Subtraction mantissa for rounding.
	reg  [12:0] subExp;   // Subtraction exponent for rounding.
	reg         subSign;  // Subtraction result sign.

	// Aligns the smaller magnitude, jams lost bits into the lsb, adds.
	always @* begin
		aBig  = {ua[74:64], ua[63:0]} >= {ub[74:64], ub[63:0]};
		bigE  = aBig ? ua[74:64] : ub[74:64];
		smlE  = aBig ? ub[74:64] : ua[74:64];
		bigM  = aBig ? ua[63:0] : ub[63:0];
		smlM  = aBig ? ub[63:0] : ua[63:0];
		bigS  = aBig ? ua[75] : ~ub[75];
		smlS  = aBig ? ~ub[75] : ua[75];
		diff  = bigE - smlE;
		smlSh = (diff >= 11'd64) ? 64'h0 : smlM >> diff[5:0];
		lost  = (diff >= 11'd64) ? (|smlM) : ((smlSh << diff[5:0]) != smlM);
		smlSh = smlSh | {63'h0, lost};
		if (bigS == smlS)
			sum = {1'b0, bigM} + {1'b0, smlSh};
		else
			sum = {1'b0, bigM} - {1'b0, smlSh};
		if (sum[64]) begin
			subMant = sum[64:1] | {63'h0, sum[0]};
			subExp  = {2'h0, bigE} + 13'h1;
		end else begin
			subMant = sum[63:0];
			subExp  = {2'h0, bigE};
		end
		// An exact zero is negative if both effective signs are, or under round toward minus if either is.
		if (sum == 65'h0)
			subSign = (bigS & smlS) | ((rndMode == `FCSU_RM_MINUS) & (bigS | smlS));
		else
			subSign = bigS;
	end

	// ------------------------------------------------------------
	// Integer to float input and shared rounding unit
	// ------------------------------------------------------------
	wire        intNeg = srcBData[31];
	wire [31:0] intMag = intNeg ? 32'h0 - srcBData[31:0] : srcBData[31:0];
	wire        isFlt  = (opCode == `FCSU_OP_FLT);
	wire [63:0] rPacked;
	wire        rOvf;
	wire        rUnf;
	wire        rInx;

	fcsu_round uRound (
		.sign     (isFlt ? intNeg : subSign),
		.expIn    (isFlt ? `FCSU_INT_EXP : subExp),
		.mantIn   (isFlt ? {intMag, 32'h0} : subMant),
		.isDouble (dblD),
		.rndMode  (rndMode),
		.rounded  (rPacked),
		.ovf      (rOvf),
		.unf      (rUnf),
		.inexact  (rInx)
	);

	// ------------------------------------------------------------
	// Float to integer datapath
	// ------------------------------------------------------------
	reg [12:0]  ue;      // Unbiased source exponent.
	reg [6:0]   sh;      // Right shift placing the binary point.
	reg [127:0] wide;    // Integer part from bit 64 up, fraction below.
	reg [31:0]  ipart;   // Rounded magnitude.
	reg [31:0]  intRes;  // Signed integer result.

	// Splits the source into integer and fraction, then rounds.
	always @* begin
		ue = {2'h0, ub[74:64]} - `FCSU_DBL_BIAS;
		if (ue[12] && ue < 13'h1FC0)
			sh = 7'h7F;
		else
			sh = 7'd63 - ue[6:0];
		wide   = {ub[63:0], 64'h0} >> sh;
		ipart  = wide[95:64] + {31'h0, roundUp(rndMode, ub[75], wide[64], wide[63],
		         |wide[62:0])};
		intRes = ub[75] ? 32'h0 - ipart : ipart;
		if (ub[63:0] == 64'h0)
			intRes = 32'h0;
	end

	wire intOvf = ~ue[12] && ue >= `FCSU_INT_OVF_EXP;

	// ------------------------------------------------------------
	// Control register access decode
	// ------------------------------------------------------------
	wire isCtlOp  = (opCode == `FCSU_OP_FSTCR) || (opCode == `FCSU_OP_FXCR);
	wire userOk   = (fpCtlSel >= `FCSU_CR_STATUS);
	wire ctlPriv  = isCtlOp && !supervisorMode && !userOk;
	wire writable = (fpCtlSel == `FCSU_CR_SCRATCH) || userOk;
	wire ctlWr    = opValid && isCtlOp && !ctlPriv && writable;

	reg [31:0] ctlRead;  // Old contents of the selected register.

	// Read mux; read-only 2-8 and unimplemented 9-61 return zero.
	always @* begin
		case (fpCtlSel)
			`FCSU_CR_SCRATCH: ctlRead = ctlScratch;
			`FCSU_CR_CAUSE:   ctlRead = {25'h0, ctlCause};
			`FCSU_CR_STATUS:  ctlRead = ctlStatus;
			`FCSU_CR_CONTROL: ctlRead = ctlControl;
			default:          ctlRead = 32'h0;
		endcase
	end

	// ------------------------------------------------------------
	// Operation outcome
	// ------------------------------------------------------------
	reg [63:0] next_data;   // Destination value.
	reg        next_write;  // Destination is written.
	reg        next_unimp;  // Unimplemented exception.
	reg        next_rsv;    // Reserved operand exception.
	reg        next_ovf;    // Overflow event.
	reg        next_unf;    // Underflow event.
	reg        next_inx;    // Inexact event, before enabling.
	reg        next_iov;    // Integer conversion overflow event.
	reg        arithOp;     // Operation is one of the three arithmetic ones.

	// Unimplemented beats reserved operand, which beats result events.
	always @* begin
		next_data  = 64'h0;
		next_write = 1'b0;
		next_unimp = 1'b0;
		next_rsv   = 1'b0;
		next_ovf   = 1'b0;
		next_unf   = 1'b0;
		next_inx   = 1'b0;
		next_iov   = 1'b0;
		arithOp    = (opCode == `FCSU_OP_FLT) || (opCode == `FCSU_OP_INT) ||
		             (opCode == `FCSU_OP_FSUB);
		if (arithOp) begin
			next_unimp = (destReg == 5'h0) || !fpuEnable ||
			             !precLegal(destPrecisionField) || !precLegal(srcBPrecisionField) ||
			             !precLegal(srcAPrecisionField);
			if (!next_unimp) begin
				case (opCode)
					`FCSU_OP_FSUB: begin
						next_rsv = ua[76] | ub[76];
						if (!next_rsv) begin
							next_data = rPacked;
							next_ovf  = rOvf;
							next_unf  = rUnf;
							next_inx  = rInx;
						end
					end
					`FCSU_OP_INT: begin
						next_rsv = ub[76];
						if (!next_rsv) begin
							next_iov  = intOvf;
							next_data = {32'h0, intRes};
						end
					end
					default: begin
						next_data = rPacked;
						next_inx  = rInx;
					end
				endcase
				next_write = !(next_rsv | next_ovf | next_unf | next_iov |
				             (next_inx & inxEn));
			end
		end else if (opCode == `FCSU_OP_FXCR && !ctlPriv) begin
			next_data  = {32'h0, ctlRead};
			next_write = 1'b1;
		end
	end

	wire trapInx = next_inx & inxEn;
	wire anyExc  = next_unimp | next_rsv | next_ovf | next_unf | next_iov | trapInx | ctlPriv;

	// ------------------------------------------------------------
	// Result and exception registers
	// ------------------------------------------------------------
	// One operation is accepted per clock; the answer stands one cycle.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			doneValid      <= 1'b0;
			resultData     <= 64'h0;
			resultDest     <= 5'h0;
			resultDouble   <= 1'b0;
			resultWrite    <= 1'b0;
			excUnimpl      <= 1'b0;
			excReserved    <= 1'b0;
			excOverflow    <= 1'b0;
			excUnderflow   <= 1'b0;
			excInexact     <= 1'b0;
			excIntOverflow <= 1'b0;
			excPrivilege   <= 1'b0;
		end else begin
			doneValid      <= opValid;
			resultData     <= opValid ? next_data : 64'h0;
			resultDest     <= opValid ? destReg : 5'h0;
			resultDouble   <= opValid && (opCode == `FCSU_OP_FLT || opCode == `FCSU_OP_FSUB) && dblD;
			resultWrite    <= opValid && next_write;
			excUnimpl      <= opValid && next_unimp;
			excReserved    <= opValid && next_rsv;
			excOverflow    <= opValid && next_ovf;
			excUnderflow   <= opValid && next_unf;
			excInexact     <= opValid && trapInx;
			excIntOverflow <= opValid && next_iov;
			excPrivilege   <= opValid && ctlPriv;
		end
	end

	// ------------------------------------------------------------
	// Control register updates
	// ------------------------------------------------------------
	// Status events are ORed after the write so a same-cycle event survives.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctlScratch <= `FCSU_CR_RESET;
			ctlCause   <= 7'h00;
			ctlStatus  <= `FCSU_CR_RESET;
			ctlControl <= `FCSU_CR_RESET;
		end else begin
			if (ctlWr && fpCtlSel == `FCSU_CR_SCRATCH)
				ctlScratch <= srcAData[31:0];
			if (ctlWr && fpCtlSel == `FCSU_CR_CONTROL)
				ctlControl <= srcAData[31:0] & `FCSU_CTL_WMASK;
			if (opValid && anyExc)
				ctlCause <= {ctlPriv, next_iov, next_rsv, next_unimp, next_unf,
				             next_ovf, trapInx};
			ctlStatus <= ((ctlWr && fpCtlSel == `FCSU_CR_STATUS) ?
			             (srcAData[31:0] & `FCSU_STS_WMASK) : ctlStatus) |
			             ({27'h0, next_rsv, next_iov, next_unf, next_ovf, next_inx} &
			             {32{opValid}});
		end
	end

endmodule

// ---- testbench/fcsu_unit_props.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checks for the conversion and control register unit.
// ------------------------------------------------------------
module fcsu_unit_props (
	input logic        mclk,
	input logic        resetn,
	input logic        opValid,
	input logic [2:0]  opCode,
	input logic [4:0]  destReg,
	input logic [1:0]  srcBPrecisionField,
	input logic [1:0]  destPrecisionField,
	input logic [5:0]  fpCtlSel,
	input logic [63:0] srcAData,
	input logic [63:0] srcBData,
	input logic        supervisorMode,
	input logic        fpuEnable,
	input logic        doneValid,
	input logic [63:0] resultData,
	input logic        resultWrite,
	input logic        excUnimpl,
	input logic        excReserved,
	input logic        excIntOverflow,
	input logic        excPrivilege
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire arith = opValid && opCode < 3'h3;  // Conversion or subtract request.
	wire ctl   = opValid && opCode > 3'h2;  // Control register store or exchange.
	// Supervisor store and then exchange of the scratch register.
	sequence stoScratch;
		ctl && opCode == 3'h3 && supervisorMode && fpCtlSel == 6'h00;
	endsequence
	sequence xcrScratch;
		ctl && opCode == 3'h4 && supervisorMode && fpCtlSel == 6'h00;
	endsequence
	AST_DONE:
	assert property (doneValid == $past(opValid)) else $error("bad done pulse");
	AST_ZERO_DEST:
	assert property (arith && destReg == 5'h00 |=> excUnimpl && !resultWrite)
		else $error("zero dest ran");
	AST_DISABLED:
	assert property (arith && !fpuEnable |=> excUnimpl) else $error("disabled unit ran");
	AST_PRIV:
	assert property (ctl && !supervisorMode && fpCtlSel < 6'h3E |=> excPrivilege && !resultWrite)
		else $error("user priv miss");
	AST_OPEN:
	assert property (ctl && fpCtlSel > 6'h3D |=> !excPrivilege) else $error("open register trapped");
	AST_UNIMP_ZERO:
	assert property (ctl && opCode == 3'h4 && supervisorMode && fpCtlSel > 6'h08
		&& fpCtlSel < 6'h3E |=> resultWrite && resultData == 64'h0) else $error("unimp not zero");
	AST_ROUNDTRIP:
	assert property (stoScratch ##1 xcrScratch |=> resultData[31:0] == $past(srcAData[31:0], 2))
		else $error("exchange lost value");
	AST_INT_OVF:
	assert property (arith && opCode == 3'h1 && destReg != 5'h00 && fpuEnable
		&& srcBPrecisionField == 2'h1 && destPrecisionField == 2'h0
		&& srcBData[62:52] > 11'h41C && srcBData[62:52] < 11'h7FF
		|=> excIntOverflow && !resultWrite) else $error("no integer overflow");
	AST_EXC_NOWRITE:
	assert property (excUnimpl || excReserved || excPrivilege |-> doneValid && !resultWrite)
		else $error("faulting op wrote");
endmodule

bind fcsu_unit fcsu_unit_props chk (.*);

// ---- testbench/fcsu_issue_model.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Issue-side model: small register file and request strobe.
// ------------------------------------------------------------
module fcsu_issue_model (
	input  wire        mclk,
	output reg         opValid,
	output reg  [2:0]  opCode,
	output reg  [4:0]  destReg,
	output reg  [1:0]  srcAPrecisionField,
	output reg  [1:0]  srcBPrecisionField,
	output reg  [1:0]  destPrecisionField,
	output reg  [5:0]  fpCtlSel,
	output reg  [63:0] srcAData,
	output reg  [63:0] srcBData,
	output reg         supervisorMode,
	output reg         fpuEnable
);
	reg [63:0] gpr [0:7];  // General registers read by requests.
	// All request lines start idle.
	initial begin
		{opValid, opCode, destReg, fpCtlSel, srcAData, srcBData} = 0;
		{srcAPrecisionField, srcBPrecisionField, destPrecisionField} = 0;
		{supervisorMode, fpuEnable} = 0;
	end
	// Present one request and hold it over the taking edge.
	task issue(input [2:0] op, input [4:0] d, input [2:0] a, input [2:0] b,
			input [5:0] p, input [5:0] sel);
		begin
			opValid = 1'b1;
			opCode = op;
			destReg = d;
			{srcAPrecisionField, srcBPrecisionField, destPrecisionField} = p;
			fpCtlSel = sel;
			srcAData = gpr[a];
			srcBData = (op > 3'h2) ? gpr[a] : gpr[b];
			@(posedge mclk);
			#1;
		end
	endtask
	// Drop the strobe and scramble the stale operands.
	task idle;
		begin
			opValid = 1'b0;
			srcAData = ~srcAData;
			srcBData = ~srcBData;
		end
	endtask
endmodule

// ---- testbench/fcsu_unit_test.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Self-checking bench for the conversion and control unit.
// ------------------------------------------------------------
module fcsu_unit_test;
	reg         mclk;
	reg         resetn;
	wire        opValid, supervisorMode, fpuEnable, doneValid, resultDouble, resultWrite;
	wire        excUnimpl, excReserved, excOverflow, excUnderflow;
	wire        excInexact, excIntOverflow, excPrivilege;
	wire [2:0]  opCode;
	wire [4:0]  destReg, resultDest;
	wire [1:0]  srcAPrecisionField, srcBPrecisionField, destPrecisionField;
	wire [5:0]  fpCtlSel;
	wire [63:0] srcAData, srcBData, resultData;
	wire [6:0]  exc = {excUnimpl, excReserved, excOverflow, excUnderflow, excInexact,
		excIntOverflow, excPrivilege};
	wire [41:0] selTab = {6'h00, 6'h01, 6'h08, 6'h09, 6'h3D, 6'h3E, 6'h3F};
	integer     fails, tests_run, cyc, seed, k, i, j;
	reg  [31:0] sh [0:63];  // Expected control register contents.
	reg  [63:0] v;
	reg  [5:0]  sel;
	reg         pv;
	fcsu_issue_model m (.*);
	fcsu_unit uut (.*);
	// ------------------------------------------------------------
	// Clock, hang guard and shared tasks.
	// ------------------------------------------------------------
	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			fails = fails + 1;
			finish_test;
		end
	end
	task finish_test;
		begin
			$display("checks %0d, mismatches %0d", tests_run, fails);
			if (fails == 0 && tests_run > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	task chk(input [63:0] s, input [63:0] e);
		begin
			tests_run = tests_run + 1;
			if (s !== e) begin
				fails = fails + 1;
				$display("CHECK FAILED at %0t: saw %h, want %h", $time, s, e);
			end
		end
	endtask
	// Issue one request and compare the answer of the following edge.
	task run(input [2:0] op, input [4:0] d, input [5:0] p, input [5:0] cs,
			input [6:0] ex, input wr, input [63:0] dat);
		begin
			m.issue(op, d, 3'h1, 3'h2, p, cs);
			chk(exc, ex);
			chk({doneValid, resultWrite, resultDest, resultDouble},
				{1'b1, wr, d, (op == 3'h0 || op == 3'h2) && p[1:0] == 2'h1});
			if (wr)
				chk(resultData, dat);
		end
	endtask
	task ld(input [63:0] a, input [63:0] b);
		begin
			m.gpr[1] = a;
			m.gpr[2] = b;
		end
	endtask
	task ctl63(input [31:0] val);
		begin
			ld({32'h0, val}, 64'h0);
			run(3'h3, 5'h3, 6'h00, 6'h3F, 7'h00, 1'b0, 64'h0);
		end
	endtask
	// Writable bits of each control register; the rest read zero.
	function [31:0] wmask(input [5:0] s);
		wmask = (s == 6'h00) ? 32'hFFFFFFFF : (s == 6'h3E) ? 32'h0000001F :
			(s == 6'h3F) ? 32'h0000C001 : 32'h0;
	endfunction
	// Expected integer of plus or minus 7.5 per rounding mode.
	function [31:0] f2i(input [1:0] md, input neg);
		f2i = neg ? ((md == 2'h0 || md == 2'h2) ? 32'hFFFFFFF8 : 32'hFFFFFFF9)
			: ((md == 2'h0 || md == 2'h3) ? 32'h8 : 32'h7);
	endfunction
	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		resetn = 1'b0;
		{fails, tests_run, cyc} = 0;
		seed = 69;
		for (k = 0; k < 64; k = k + 1)
			sh[k] = 32'h0;
		repeat (20) @(posedge mclk);
		#1;
		resetn = 1'b1;
		m.fpuEnable = 1'b1;
		// Store, then exchange, each register class; supervisor first.
		for (k = 0; k < 14; k = k + 1) begin
			sel = selTab[6 * (k % 7) +: 6];
			m.supervisorMode = (k < 7);
			pv = (k > 6) && (sel < 6'h3E);
			for (j = 0; j < 2; j = j + 1) begin
				v = {$random(seed), $random(seed)};
				ld(v, 64'h0);
				run(3'h3 + j, 5'h3, 6'h00, sel, {6'h0, pv}, j && !pv, {32'h0, sh[sel]});
				if (!pv && wmask(sel) != 32'h0)
					sh[sel] = v[31:0] & wmask(sel);
			end
		end
		m.supervisorMode = 1'b1;
		ctl63(32'h0);
		$display("control register test done");
		// Zero destination, then disabled unit, for every arithmetic op.
		for (k = 0; k < 6; k = k + 1) begin
			m.fpuEnable = (k < 3);
			run(k % 3, (k < 3) ? 5'h0 : 5'h3, 6'h05, 6'h00, 7'h40, 1'b0, 64'h0);
		end
		m.fpuEnable = 1'b1;
		// Random integers to double, and their exact differences.
		for (k = 0; k < 8; k = k + 1) begin
			i = $random(seed);
			j = $random(seed);
			ld($realtobits($itor(i)), {$random(seed), i});
			run(3'h0, 5'h3, 6'h01, 6'h00, 7'h00, 1'b1, $realtobits($itor(i)));
			m.gpr[2] = $realtobits($itor(j));
			run(3'h2, 5'h4, 6'h15, 6'h00, 7'h00, 1'b1, $realtobits($itor(i) - $itor(j)));
		end
		ld(64'h0, 64'hFFFFFFFFFFFFFFFD);
		run(3'h0, 5'h3, 6'h00, 6'h00, 7'h00, 1'b1, 64'hC0400000);
		// 1.5 minus 0.25 in all eight precision mixes.
		for (k = 0; k < 8; k = k + 1) begin
			ld(k[2] ? 64'h3FF8000000000000 : 64'hFFFFFFFF3FC00000,
				k[1] ? 64'h3FD0000000000000 : 64'h3E800000);
			run(3'h2, 5'h5, {1'b0, k[2], 1'b0, k[1], 1'b0, k[0]}, 6'h00, 7'h00, 1'b1,
				k[0] ? 64'h3FF4000000000000 : 64'h3FA00000);
		end
		ld(64'h7FF0000000000000, 64'h3FF0000000000000);
		run(3'h2, 5'h3, 6'h15, 6'h00, 7'h20, 1'b0, 64'h0);
		ld(64'h7FEFFFFFFFFFFFFF, 64'hFFEFFFFFFFFFFFFF);
		run(3'h2, 5'h3, 6'h15, 6'h00, 7'h10, 1'b0, 64'h0);
		ld(64'h0010000000000000, 64'h0010000000000001);
		run(3'h2, 5'h3, 6'h15, 6'h00, 7'h08, 1'b0, 64'h0);
		ld(64'h3FF0000000000000, 64'h3C30000000000000);
		run(3'h2, 5'h3, 6'h15, 6'h00, 7'h00, 1'b1, 64'h3FF0000000000000);
		ctl63(32'h1);
		ld(64'h3FF0000000000000, 64'h3C30000000000000);
		run(3'h2, 5'h3, 6'h15, 6'h00, 7'h04, 1'b0, 64'h0);
		$display("subtract test done");
		// Float to integer under every rounding mode, both signs.
		for (k = 0; k < 8; k = k + 1) begin
			ctl63({16'h0, k[2:1], 14'h0});
			ld(64'h0, k[0] ? 64'hC01E000000000000 : 64'h401E000000000000);
			run(3'h1, 5'h3, 6'h04, 6'h00, 7'h00, 1'b1, {32'h0, f2i(k[2:1], k[0])});
		end
		ctl63(32'h0);
		ld(64'h0, 64'h41D0000000000000);
		run(3'h1, 5'h3, 6'h04, 6'h00, 7'h02, 1'b0, 64'h0);
		ld(64'h0, 64'h41C0000000000000);
		run(3'h1, 5'h3, 6'h04, 6'h00, 7'h00, 1'b1, 64'h20000000);
		ld(64'h0, 64'h7FF8000000000000);
		run(3'h1, 5'h3, 6'h04, 6'h00, 7'h20, 1'b0, 64'h0);
		m.idle;
		@(posedge mclk);
		#1;
		chk({doneValid, resultWrite, exc}, 9'h0);
		$display("float to integer test done");
		finish_test;
	end
endmodule
